// ===== adcc_pkg.sv
// Package for the converter control block: offsets, fields, reset values, timing.
// Assumes a 32-bit classic Wishbone register bus on word-aligned byte addresses.
package adcc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADCC_OFS_SC1  = 8'h00; // Status and control one
    localparam logic [7:0] ADCC_OFS_SC2  = 8'h04; // Trigger and compare control
    localparam logic [7:0] ADCC_OFS_RESH = 8'h08; // Result high
    localparam logic [7:0] ADCC_OFS_RESL = 8'h0C; // Result low
    localparam logic [7:0] ADCC_OFS_CVH  = 8'h10; // Compare value high
    localparam logic [7:0] ADCC_OFS_CVL  = 8'h14; // Compare value low
    localparam logic [7:0] ADCC_OFS_CFG  = 8'h18; // Configuration (resolution)
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ADCC_BIT_DONE  = 7; // Conversion done flag
    localparam int ADCC_BIT_IEN   = 6; // Done interrupt enable
    localparam int ADCC_BIT_CONT  = 5; // Continuous enable
    localparam int ADCC_BIT_ACT   = 7; // Conversion active (sc2)
    localparam int ADCC_BIT_TRG   = 6; // Trigger source select (sc2)
    localparam int ADCC_BIT_CFE   = 5; // Compare enable (sc2)
    localparam int ADCC_BIT_CGE   = 4; // Compare greater equal (sc2)
    localparam int ADCC_BIT_MODE8 = 0; // 8-bit resolution (cfg)
    // ------------------------------------------------------------
    // Reset values and channel codes
    // ------------------------------------------------------------
    localparam logic [4:0] ADCC_CH_OFF     = 5'h1F; // Module disabled
    localparam logic [4:0] ADCC_CH_RSVD    = 5'h1C; // Reserved code
    localparam logic [4:0] ADCC_CH_HIGH_REFERENCE   = 5'h1D; // High reference
    localparam logic [4:0] ADCC_CH_LOW_REFERENCE   = 5'h1E; // Low reference
    localparam logic [4:0] ADCC_CH_LASTPIN = 5'h1B; // Last analog input
    localparam logic [7:0] ADCC_SC1_RST    = 8'h1F; // Disabled after reset
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ADCC_CLK_HZ      = 10_000_000;
    localparam int ADCC_CONV_NS     = 2_000; // One conversion time
    localparam int ADCC_CONV_CYC    = ADCC_CONV_NS / (1_000_000_000 / ADCC_CLK_HZ);
    localparam logic [7:0] ADCC_CONV_CYC8 = 8'(ADCC_CONV_CYC);
    // Successive approximation FSM
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_CONV = 2'b01,
        ADCC_DONE = 2'b11
    } adcc_state_e;
endpackage : adcc_pkg

// ===== adcc_trig_sync.sv
// Hardware trigger pulse catcher: turns the trigger level into one-cycle pulses.
// Assumes the trigger source is synchronous to core_clk.
`timescale 1ns/1ps
module adcc_trig_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic trig_in,
    output logic      trig_pulse
);
    logic last_ff; // Previous trigger level
    // ------------------------------------------------------------
    // Rising edge detect, one pulse per assertion
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_ff <= 1'b0;
        end else if (clk_en) begin
            last_ff <= trig_in;
        end
    end
    assign trig_pulse = clk_en & trig_in & ~last_ff;
endmodule : adcc_trig_sync

// ===== adcc_ctrl.sv
// Converter control top: Wishbone registers, start logic, result and compare.
// Assumes a synchronous analog core returning a 10-bit sample on ana_sample.
`timescale 1ns/1ps
module adcc_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        hardware_trigger_in,
    input  wire logic [9:0]  ana_sample,
    output logic             ana_power_on,
    output logic [4:0]       ana_channel,
    output logic             ana_sel_high_reference,
    output logic             ana_sel_low_reference,
    output logic             done_irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]  sc1_ff;          // Status and control one, done flag kept apart
    logic        done_ff;         // conversion_done_flag
    logic        trg_ff;          // trigger_source_select
    logic        cfe_ff;          // compare_enable
    logic        cge_ff;          // compare_greater_equal
    logic        mode8_ff;        // 8-bit resolution
    logic [9:0]  cmp_ff;          // Compare value
    logic [9:0]  res_ff;          // Result register
    logic        lock_ff;         // High read seen, waiting for low read
    logic [7:0]  cnt_ff;          // Conversion cycle counter
    logic        armed_ff;        // Continuous run in progress
    adcc_pkg::adcc_state_e state_ff; // Converter state
    logic        trig_pulse;      // Synchronised trigger pulse
    logic        bus_req;         // New bus access this cycle
    logic        wr_sc1;          // Write to status and control one
    logic        rd_resl;         // Read of low result
    logic        rd_resh;         // Read of high result
    logic        ch_off;          // Channel set to disabled
    logic        start;           // Begin a conversion
    logic        finish;          // Conversion completes this cycle
    logic        cmp_true;        // Compare condition
    logic [9:0]  sample_fmt;      // Formatted sample
    logic [7:0]  rd_mux;          // Read data
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare of result against value; 8-bit mode ignores the high bits
    function automatic logic adcc_cmp(input logic [9:0] r, input logic [9:0] c,
                                      input logic ge, input logic m8);
        logic [9:0] rr;
        logic [9:0] cc;
        rr = m8 ? {2'b00, r[7:0]} : r;
        cc = m8 ? {2'b00, c[7:0]} : c;
        adcc_cmp = ge ? (rr >= cc) : (rr < cc);
    endfunction : adcc_cmp

    adcc_trig_sync u_trig (
        .core_clk   (core_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .trig_in    (hardware_trigger_in),
        .trig_pulse (trig_pulse)
    );
    // Trigger is edge-detected on core_clk and gated by clk_en, so it is only caught while clk_en is high.

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign bus_req = clk_en & wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_sc1  = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == adcc_pkg::ADCC_OFS_SC1);
    assign rd_resl = bus_req & ~wb_we_i & (wb_adr_i == adcc_pkg::ADCC_OFS_RESL);
    assign rd_resh = bus_req & ~wb_we_i & (wb_adr_i == adcc_pkg::ADCC_OFS_RESH);
    assign ch_off  = (sc1_ff[4:0] == adcc_pkg::ADCC_CH_OFF);

    // Start: software write in software mode, trigger pulse in hardware mode
    always_comb begin
        if (wr_sc1) begin
            start = (wb_dat_i[4:0] != adcc_pkg::ADCC_CH_OFF) & ~trg_ff;
        end else if (trg_ff && trig_pulse && !ch_off && state_ff == adcc_pkg::ADCC_IDLE) begin
            start = 1'b1;
        end else if (armed_ff && !ch_off && state_ff == adcc_pkg::ADCC_IDLE) begin
            start = 1'b1;
        end else begin
            start = 1'b0;
        end
    end

    assign finish     = clk_en & (state_ff == adcc_pkg::ADCC_CONV)
                        & (cnt_ff == adcc_pkg::ADCC_CONV_CYC8 - 8'h01) & ~wr_sc1;
    assign sample_fmt = mode8_ff ? {2'b00, ana_sample[9:2]} : ana_sample;
    assign cmp_true   = adcc_cmp(sample_fmt, cmp_ff, cge_ff, mode8_ff);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sc1_ff   <= adcc_pkg::ADCC_SC1_RST;
            trg_ff   <= 1'b0;
            cfe_ff   <= 1'b0;
            cge_ff   <= 1'b0;
            mode8_ff <= 1'b0;
            cmp_ff   <= 10'h000;
        end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == adcc_pkg::ADCC_OFS_SC1) begin
                sc1_ff <= {1'b0, wb_dat_i[6:0]};
            end else if (wb_adr_i == adcc_pkg::ADCC_OFS_SC2) begin
                trg_ff <= wb_dat_i[adcc_pkg::ADCC_BIT_TRG];
                cfe_ff <= wb_dat_i[adcc_pkg::ADCC_BIT_CFE];
                cge_ff <= wb_dat_i[adcc_pkg::ADCC_BIT_CGE];
            end else if (wb_adr_i == adcc_pkg::ADCC_OFS_CVH) begin
                cmp_ff[9:8] <= wb_dat_i[1:0];
            end else if (wb_adr_i == adcc_pkg::ADCC_OFS_CVL) begin
                cmp_ff[7:0] <= wb_dat_i[7:0];
            end else if (wb_adr_i == adcc_pkg::ADCC_OFS_CFG) begin
                mode8_ff <= wb_dat_i[adcc_pkg::ADCC_BIT_MODE8];
            end
        end
    end

    // ------------------------------------------------------------
    // Converter sequencing
    // ------------------------------------------------------------
    // Writes abort by restarting the counter; off code returns to idle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= adcc_pkg::ADCC_IDLE;
            cnt_ff   <= 8'h00;
            armed_ff <= 1'b0;
        end else if (clk_en) begin
            if (wr_sc1) begin
                state_ff <= start ? adcc_pkg::ADCC_CONV : adcc_pkg::ADCC_IDLE;
                cnt_ff   <= 8'h00;
                // Continuous software run arms here, off code disarms.
                armed_ff <= start & wb_dat_i[adcc_pkg::ADCC_BIT_CONT];
            end else if (start) begin
                state_ff <= adcc_pkg::ADCC_CONV;
                cnt_ff   <= 8'h00;
                armed_ff <= sc1_ff[adcc_pkg::ADCC_BIT_CONT];
            end else if (finish) begin
                state_ff <= adcc_pkg::ADCC_DONE;
            end else if (state_ff == adcc_pkg::ADCC_CONV) begin
                cnt_ff <= cnt_ff + 8'h01;
            end else if (state_ff == adcc_pkg::ADCC_DONE) begin
                // Single mode falls back to idle and low power.
                state_ff <= adcc_pkg::ADCC_IDLE;
                armed_ff <= armed_ff & sc1_ff[adcc_pkg::ADCC_BIT_CONT];
            end
        end
    end

    // ------------------------------------------------------------
    // Done flag and result
    // ------------------------------------------------------------
    // Set wins over clear when both arrive together.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_ff <= 1'b0;
        end else if (finish && (!cfe_ff || cmp_true)) begin
            done_ff <= 1'b1;
        end else if (wr_sc1 || rd_resl) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            res_ff  <= 10'h000;
            lock_ff <= 1'b0;
        end else begin
            if (finish && (!cfe_ff || cmp_true) && !lock_ff) begin
                res_ff <= sample_fmt;
            end
            if (rd_resl) begin
                lock_ff <= 1'b0;
            end else if (rd_resh && !mode8_ff) begin
                lock_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer and outputs
    // ------------------------------------------------------------
    always_comb begin
        if (wb_adr_i == adcc_pkg::ADCC_OFS_SC1) begin
            rd_mux = {done_ff, sc1_ff[6:0]};
        end else if (wb_adr_i == adcc_pkg::ADCC_OFS_SC2) begin
            rd_mux = {state_ff == adcc_pkg::ADCC_CONV, trg_ff, cfe_ff, cge_ff, 4'h0};
        end else if (wb_adr_i == adcc_pkg::ADCC_OFS_RESH) begin
            rd_mux = {6'h00, res_ff[9:8]};
        end else if (wb_adr_i == adcc_pkg::ADCC_OFS_RESL) begin
            rd_mux = res_ff[7:0];
        end else if (wb_adr_i == adcc_pkg::ADCC_OFS_CVH) begin
            rd_mux = {6'h00, cmp_ff[9:8]};
        end else if (wb_adr_i == adcc_pkg::ADCC_OFS_CVL) begin
            rd_mux = cmp_ff[7:0];
        end else if (wb_adr_i == adcc_pkg::ADCC_OFS_CFG) begin
            rd_mux = {7'h00, mode8_ff};
        end else begin
            rd_mux = 8'h00;   // Unmapped reads zero, still acknowledged
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // Channel decode to analog mux.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ana_power_on  <= 1'b0;
            ana_channel   <= 5'h00;
            ana_sel_high_reference <= 1'b0;
            ana_sel_low_reference <= 1'b0;
            done_irq      <= 1'b0;
        end else if (clk_en) begin
            ana_power_on  <= (state_ff == adcc_pkg::ADCC_CONV) | start;
            ana_channel   <= (sc1_ff[4:0] <= adcc_pkg::ADCC_CH_LASTPIN) ? sc1_ff[4:0] : 5'h00;
            ana_sel_high_reference <= (sc1_ff[4:0] == adcc_pkg::ADCC_CH_HIGH_REFERENCE);
            ana_sel_low_reference <= (sc1_ff[4:0] == adcc_pkg::ADCC_CH_LOW_REFERENCE);
            done_irq      <= done_ff & sc1_ff[adcc_pkg::ADCC_BIT_IEN];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_finish_ok;
        finish && (!cfe_ff || cmp_true);
    endsequence

    // Continuous run waits in idle, still armed, for the next start
    sequence s_rearm_idle;
        state_ff == adcc_pkg::ADCC_IDLE && armed_ff;
    endsequence

    a_done_on_finish: assert property (@(posedge core_clk) disable iff (rst)
        s_finish_ok |=> done_ff)
        else $error("done flag not set after finish");
    a_cmp_false_hold: assert property (@(posedge core_clk) disable iff (rst)
        finish && cfe_ff && !cmp_true && !done_ff && clk_en |=> !done_ff)
        else $error("done set although compare false");
    a_clear_on_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_sc1 && !finish |=> !done_ff)
        else $error("done not cleared by write");
    a_irq_follows: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && done_ff && sc1_ff[adcc_pkg::ADCC_BIT_IEN] |=> done_irq)
        else $error("interrupt not raised");
    a_off_no_conv: assert property (@(posedge core_clk) disable iff (rst)
        ch_off && !wr_sc1 |-> !start)
        else $error("conversion started while disabled");
    a_single_idle: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && state_ff == adcc_pkg::ADCC_DONE && !sc1_ff[adcc_pkg::ADCC_BIT_CONT]
        && !wr_sc1 |=> state_ff == adcc_pkg::ADCC_IDLE)
        else $error("single conversion did not return idle");
    a_write_restart: assert property (@(posedge core_clk) disable iff (rst)
        wr_sc1 && !trg_ff && wb_dat_i[4:0] != adcc_pkg::ADCC_CH_OFF
        |=> state_ff == adcc_pkg::ADCC_CONV && cnt_ff == 8'h00)
        else $error("write did not restart conversion");
    a_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
        lock_ff && !rd_resl |=> $stable(res_ff))
        else $error("result changed while locked");
    a_start_active: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && start |=> state_ff == adcc_pkg::ADCC_CONV)
        else $error("start did not enter conversion");
    a_cont_rearm: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && state_ff == adcc_pkg::ADCC_DONE && armed_ff
        && sc1_ff[adcc_pkg::ADCC_BIT_CONT] && !wr_sc1 |=> s_rearm_idle)
        else $error("continuous run not rearmed");
    a_cmp_ge_sets: assert property (@(posedge core_clk) disable iff (rst)
        finish && cfe_ff && cge_ff && !mode8_ff && sample_fmt >= cmp_ff |=> done_ff)
        else $error("greater-equal compare did not set done");
    a_off_power_down: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && ch_off && state_ff == adcc_pkg::ADCC_IDLE && !wr_sc1 |=> !ana_power_on)
        else $error("converter powered while disabled");
endmodule : adcc_ctrl

// ===== adcc_ana_model.sv
// Far-side model: analog sample source and trigger source driven by fire.
// Assumes the control block reads ana_sample while ana_power_on is high.
`timescale 1ns/1ps
module adcc_ana_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       fire,
    input  wire logic       ana_power_on,
    input  wire logic [4:0] ana_channel,
    input  wire logic       ana_sel_high_reference,
    input  wire logic       ana_sel_low_reference,
    output logic      [9:0] ana_sample,
    output logic            hardware_trigger_in
);
    // ------------------------------------------------------------
    // Sample source
    // ------------------------------------------------------------
    logic [9:0] last_ff; // Last value seen while powered

    // Unpowered core shows inverted stale data so a late read is caught
    always_comb begin
        if (!ana_power_on) begin
            ana_sample = ~last_ff;
        end else if (ana_sel_high_reference) begin
            ana_sample = 10'h3FF;
        end else if (ana_sel_low_reference) begin
            ana_sample = 10'h000;
        end else begin
            ana_sample = {ana_channel, 5'h0A};
        end
    end

    // Track last powered sample
    always_ff @(posedge core_clk) begin
        if (ana_power_on) begin
            last_ff <= ana_sample;
        end
    end

    // ------------------------------------------------------------
    // Trigger source
    // ------------------------------------------------------------
    // One-cycle pulse per request, in step with the bus clock
    // Fires in any core power mode; the pulse is fire delayed by one clock.
    always_ff @(posedge core_clk) begin
        hardware_trigger_in <= rst ? 1'b0 : fire;
    end
endmodule : adcc_ana_model

// ===== tb.sv
// Self-checking bench for the converter control block.
// Assumes 10 MHz core_clk, a synchronous reset and classic Wishbone.
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] SC1 = adcc_pkg::ADCC_OFS_SC1;
    localparam logic [7:0] SC2 = adcc_pkg::ADCC_OFS_SC2;
    localparam logic [7:0] RSH = adcc_pkg::ADCC_OFS_RESH;
    localparam logic [7:0] RSL = adcc_pkg::ADCC_OFS_RESL;
    logic        core_clk = 1'b0; // Bus clock
    logic        rst      = 1'b1; // Sync reset
    logic        cyc      = 1'b0; // Bus cycle
    logic        stb      = 1'b0; // Bus strobe
    logic        we       = 1'b0; // Write select
    logic        fire     = 1'b0; // Trigger request to model
    logic        ce       = 1'b1; // Clock enable to the block
    logic [7:0]  adr      = 8'h00;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] rd;              // Last read data
    logic [31:0] dat_o;
    logic        ack, trig, pwr, vh, vl, irq;
    logic [4:0]  chan;
    logic [9:0]  samp;
    logic [31:0] exp_l [3] = '{32'h0A, 32'hFF, 32'h00}; // Reserved, high, low refs
    int          fail_count = 0;
    int          checks_done = 0;

    always #50 core_clk = ~core_clk;

    adcc_ctrl dut_u (.core_clk(core_clk), .rst(rst), .clk_en(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .hardware_trigger_in(trig), .ana_sample(samp),
        .ana_power_on(pwr), .ana_channel(chan), .ana_sel_high_reference(vh), .ana_sel_low_reference(vl),
        .done_irq(irq));
    adcc_ana_model ana_u (.core_clk(core_clk), .rst(rst), .fire(fire), .ana_power_on(pwr),
        .ana_channel(chan), .ana_sel_high_reference(vh), .ana_sel_low_reference(vl), .ana_sample(samp),
        .hardware_trigger_in(trig));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    // One classic cycle; held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) fail_count++;
    endtask : wb_xfer

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    // Skip the two-cycle irq lag, then poll within a bounded window
    task automatic wait_irq(input logic exp);
        int n;
        repeat (2) @(posedge core_clk);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, irq}, {31'h0, exp});
    endtask : wait_irq

    task automatic end_sim;
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // Watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(SC1, 32'h1F);
        rd_chk(SC2, 32'h00);
        rd_chk(8'h1C, 32'h00);
        // Software single conversion on input 3
        wb_xfer(1'b1, SC1, 32'h43);
        rd_chk(SC2, 32'h80);
        wait_irq(1'b1);
        rd_chk(SC1, 32'hC3);
        chk({31'h0, pwr}, 32'h0);
        rd_chk(RSH, 32'h0);
        rd_chk(RSL, 32'h6A);
        rd_chk(SC1, 32'h43);
        rd_chk(SC2, 32'h00);
        // Clock enable low freezes a running conversion on input 1
        wb_xfer(1'b1, SC1, 32'h41);
        ce <= 1'b0;
        repeat (30) @(posedge core_clk);
        chk({31'h0, pwr}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        wait_irq(1'b1);
        rd_chk(RSL, 32'h2A);
        // Abort in mid-conversion, restart on input 27
        wb_xfer(1'b1, SC1, 32'h43);
        repeat (5) @(posedge core_clk);
        wb_xfer(1'b1, SC1, 32'h5B);
        wait_irq(1'b1);
        rd_chk(RSH, 32'h3);
        rd_chk(RSL, 32'h6A);
        wb_xfer(1'b1, SC1, 32'h1F);
        rd_chk(SC1, 32'h1F);
        // Reserved and reference codes
        for (int i = 0; i < 3; i++) begin
            wb_xfer(1'b1, SC1, 32'h5C + i);
            wait_irq(1'b1);
            rd_chk(RSL, exp_l[i]);
        end
        // Reading high first locks the result until the low read
        wb_xfer(1'b1, SC1, 32'h43);
        wait_irq(1'b1);
        rd_chk(RSH, 32'h0);
        wb_xfer(1'b1, SC1, 32'h41);
        repeat (30) @(posedge core_clk);
        rd_chk(RSL, 32'h6A);
        // Eight-bit result
        wb_xfer(1'b1, adcc_pkg::ADCC_OFS_CFG, 32'h1);
        wb_xfer(1'b1, SC1, 32'h5D);
        wait_irq(1'b1);
        rd_chk(RSL, 32'hFF);
        rd_chk(RSH, 32'h0);
        wb_xfer(1'b1, adcc_pkg::ADCC_OFS_CFG, 32'h0);
        // Compare against 0x200: less-than false, then greater-equal true
        wb_xfer(1'b1, adcc_pkg::ADCC_OFS_CVH, 32'h2);
        wb_xfer(1'b1, adcc_pkg::ADCC_OFS_CVL, 32'h0);
        wb_xfer(1'b1, SC2, 32'h20);
        wb_xfer(1'b1, SC1, 32'h5B);
        wait_irq(1'b0);
        wb_xfer(1'b1, SC2, 32'h30);
        wb_xfer(1'b1, SC1, 32'h5B);
        wait_irq(1'b1);
        rd_chk(RSL, 32'h6A);
        wb_xfer(1'b1, SC2, 32'h00);
        // Continuous mode then disable code
        wb_xfer(1'b1, SC1, 32'h7B);
        wait_irq(1'b1);
        rd_chk(RSL, 32'h6A);
        wait_irq(1'b1);
        wb_xfer(1'b1, SC1, 32'h1F);
        repeat (30) @(posedge core_clk);
        chk({31'h0, pwr}, 32'h0);
        rd_chk(SC1, 32'h1F);
        // Hardware trigger: write alone starts nothing, one pulse one conversion
        wb_xfer(1'b1, SC2, 32'h40);
        wb_xfer(1'b1, SC1, 32'h41);
        repeat (3) @(posedge core_clk);
        chk({31'h0, pwr}, 32'h0);
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        wait_irq(1'b1);
        rd_chk(RSL, 32'h2A);
        wait_irq(1'b0);
        end_sim();
    end
endmodule : tb
